// ---- cpu_addr_pkg.sv ----
package cpu_addr_pkg;

    // Flag register layout
    localparam logic [7:0] FLAGS_ADDR = 8'hF7;
    localparam int FLAG_GIE = 0;
    localparam int FLAG_ZERO = 1;
    localparam int FLAG_CARRY = 2;
    localparam int FLAG_BANK = 4;
    localparam logic [7:0] FLAGS_RESET = 8'h02;
    localparam logic [7:0] FLAGS_WMASK = 8'h17;

    // Reset values of the core registers
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] IDX_RESET = 8'h00;
    localparam logic [7:0] SP_RESET = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;

    // Opcode landmarks
    localparam logic [7:0] OPC_ALU_LAST = 8'h37;
    localparam logic [7:0] OPC_ADD_SP = 8'h38;
    localparam logic [7:0] OPC_REG_ALU_FIRST = 8'h41;
    localparam logic [7:0] OPC_REG_ALU_LAST = 8'h46;
    localparam logic [7:0] OPC_MOV_FIRST = 8'h50;
    localparam logic [7:0] OPC_MOV_LAST = 8'h63;
    localparam logic [7:0] OPC_F_FIRST = 8'h70;
    localparam logic [7:0] OPC_F_LAST = 8'h72;

    // Instruction lengths in bytes
    localparam logic [1:0] LEN1 = 2'h1;
    localparam logic [1:0] LEN2 = 2'h2;
    localparam logic [1:0] LEN3 = 2'h3;

    typedef enum logic [2:0] {
        OP_MOV = 3'h0,
        OP_ADD = 3'h1,
        OP_ADC = 3'h2,
        OP_SUB = 3'h3,
        OP_SBB = 3'h4,
        OP_AND = 3'h5,
        OP_OR = 3'h6,
        OP_XOR = 3'h7
    } alu_op_t;

    typedef enum logic [2:0] {
        L_NONE = 3'h0,
        L_A = 3'h1,
        L_X = 3'h2,
        L_SP = 3'h3,
        L_F = 3'h4,
        L_IMM1 = 3'h5,
        L_IMM2 = 3'h6,
        L_MEM = 3'h7
    } loc_t;

    typedef struct packed {
        alu_op_t op;
        loc_t dst;
        loc_t src;
        loc_t sec;
        logic idx;
        logic regsp;
        logic mem2;
        logic [1:0] len;
    } dec_t;

endpackage

// ---- alu_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface alu_if;
    import cpu_addr_pkg::*;
    logic [7:0] a;
    logic [7:0] b;
    logic cin;
    alu_op_t op;
    logic [7:0] res;
    logic cout;
    modport user (output a, output b, output cin, output op,
                  input res, input cout);
    modport unit (input a, input b, input cin, input op,
                  output res, output cout);
endinterface
`default_nettype wire

// ---- alu_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module alu_unit
    import cpu_addr_pkg::*;
(
    alu_if.unit alu
);
    logic [8:0] wide;

    // a is the new operand, b the second operand; carry is borrow on sub
    always_comb
    begin
        wide = 9'h000;
        case (alu.op)
            OP_MOV: wide = {1'b0, alu.a};
            OP_ADD: wide = {1'b0, alu.b} + {1'b0, alu.a};
            OP_ADC: wide = {1'b0, alu.b} + {1'b0, alu.a} + {8'h00, alu.cin};
            OP_SUB: wide = {1'b0, alu.b} - {1'b0, alu.a};
            OP_SBB: wide = {1'b0, alu.b} - {1'b0, alu.a} - {8'h00, alu.cin};
            OP_AND: wide = {1'b0, alu.b & alu.a};
            OP_OR: wide = {1'b0, alu.b | alu.a};
            OP_XOR: wide = {1'b0, alu.b ^ alu.a};
            default: wide = 9'h000;
        endcase
        alu.res = wide[7:0];
        alu.cout = wide[8];
    end
endmodule
`default_nettype wire

// ---- cpu_operand_addressing.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpu_operand_addressing
    import cpu_addr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    output logic [15:0] prog_addr,
    input wire logic [7:0] prog_data,
    output logic [7:0] mem_addr,
    output logic mem_reg,
    output logic mem_bank,
    output logic mem_rd,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    output logic global_interrupt_enable,
    output logic [7:0] accumulator,
    output logic [7:0] index_register,
    output logic [7:0] stack_pointer,
    output logic [7:0] cpu_flags,
    output logic instr_done
);
    typedef enum logic [6:0] {
        S_ADDR = 7'h01,
        S_LATCH = 7'h02,
        S_DECODE = 7'h04,
        S_MEMRD = 7'h08,
        S_MEMDAT = 7'h10,
        S_EXEC = 7'h20,
        S_WR = 7'h40
    } state_t;

    typedef struct packed {
        state_t st;
        logic [7:0] pc_hi;
        logic [7:0] pc_lo;
        logic [7:0] a;
        logic [7:0] x;
        logic [7:0] sp;
        logic [7:0] f;
        logic [7:0] opc;
        logic [7:0] op1;
        logic [7:0] op2;
        logic [1:0] cnt;
        logic [7:0] rdat;
        logic [7:0] maddr;
        logic mreg;
        logic mbank;
        logic mrd;
        logic mwr;
        logic [7:0] mwdata;
        logic done;
    } core_t;

    core_t r_q;
    core_t r_d;
    dec_t dec;
    dec_t dec_new;
    logic [15:0] pc;
    logic [7:0] dst_addr;
    logic [7:0] src_addr;
    logic set_flags;

    alu_if alu ();

    alu_unit u_alu (
        .alu(alu)
    );

    function automatic dec_t decode(input logic [7:0] o);
        dec_t d;
        d = '{op: OP_MOV, dst: L_NONE, src: L_NONE, sec: L_NONE,
              idx: 1'b0, regsp: 1'b0, mem2: 1'b0, len: LEN1};
        if (o <= OPC_ALU_LAST && o[2:0] != 3'h0)
        begin
            d.op = alu_op_t'(o[5:3] + 3'h1);
            d.idx = o[0];
            d.len = LEN2;
            case (o[2:0])
                3'h1: d = '{d.op, L_A, L_IMM1, L_A, 1'b0, 1'b0, 1'b0, LEN2};
                3'h2, 3'h3:
                begin
                    d.dst = L_A;
                    d.src = L_MEM;
                    d.sec = L_A;
                end
                3'h4, 3'h5:
                begin
                    d.dst = L_MEM;
                    d.src = L_A;
                    d.sec = L_MEM;
                end
                default:
                begin
                    d.dst = L_MEM;
                    d.src = L_IMM2;
                    d.sec = L_MEM;
                    d.len = LEN3;
                end
            endcase
        end
        else if (o == OPC_ADD_SP)
            d = '{OP_ADD, L_SP, L_IMM1, L_SP, 1'b0, 1'b0, 1'b0, LEN2};
        else if (o >= OPC_REG_ALU_FIRST && o <= OPC_REG_ALU_LAST)
        begin
            d.op = alu_op_t'(3'(OP_AND) + 3'((o - OPC_REG_ALU_FIRST) >> 1));
            d = '{d.op, L_MEM, L_IMM2, L_MEM, ~o[0], 1'b1, 1'b0, LEN3};
        end
        else if (o >= OPC_F_FIRST && o <= OPC_F_LAST)
        begin
            d.op = alu_op_t'(3'(OP_AND) + o[2:0]);
            d = '{d.op, L_F, L_IMM1, L_F, 1'b0, 1'b0, 1'b0, LEN2};
        end
        else if (o >= OPC_MOV_FIRST && o <= OPC_MOV_LAST)
        begin
            d.len = LEN2;
            case (o[4:0])
                5'h10: d.dst = L_A;
                5'h11, 5'h12, 5'h1D, 5'h1E: d.dst = L_A;
                5'h13, 5'h14, 5'h00, 5'h01: d.dst = L_MEM;
                5'h15, 5'h16, 5'h02, 5'h03: d.dst = L_MEM;
                5'h17, 5'h18, 5'h19: d.dst = L_X;
                5'h1A, 5'h1F: d.dst = L_MEM;
                default: d.len = LEN1;
            endcase
            case (o[4:0])
                5'h10, 5'h17: d.src = L_IMM1;
                5'h11, 5'h12, 5'h18, 5'h19, 5'h1D, 5'h1E: d.src = L_MEM;
                5'h13, 5'h14, 5'h00, 5'h01: d.src = L_A;
                5'h15, 5'h16, 5'h02, 5'h03: d.src = L_IMM2;
                5'h1A: d.src = L_X;
                5'h1F: d.src = L_MEM;
                default: d.src = L_NONE;
            endcase
            case (o[4:0])
                5'h12, 5'h14, 5'h16, 5'h19, 5'h1E, 5'h01, 5'h03: d.idx = 1'b1;
                default: d.idx = 1'b0;
            endcase
            d.regsp = (o >= 8'h5D && o != 8'h5F);
            d.mem2 = (o == 8'h5F);
            if (d.src == L_IMM2 || d.mem2)
                d.len = LEN3;
        end
        return d;
    endfunction

    function automatic logic [7:0] pick(input loc_t l, input core_t c);
        case (l)
            L_A: pick = c.a;
            L_X: pick = c.x;
            L_SP: pick = c.sp;
            L_F: pick = c.f;
            L_IMM1: pick = c.op1;
            L_IMM2: pick = c.op2;
            L_MEM: pick = c.rdat;
            default: pick = 8'h00;
        endcase
    endfunction

    assign dec = decode(r_q.opc);
    assign dec_new = decode(prog_data);
    assign pc = {r_q.pc_hi, r_q.pc_lo};
    assign dst_addr = r_q.op1 + (dec.idx ? r_q.x : 8'h00);
    assign src_addr = dec.mem2 ? r_q.op2 : dst_addr;
    assign set_flags = r_q.st == S_EXEC && dec.dst != L_F &&
                       (dec.op != OP_MOV || dec.dst == L_A);

    assign alu.a = pick(dec.src, r_q);
    assign alu.b = pick(dec.sec, r_q);
    assign alu.cin = r_q.f[FLAG_CARRY];
    assign alu.op = dec.op;

    always_comb
    begin
        r_d = r_q;
        r_d.done = 1'b0;
        r_d.mrd = 1'b0;
        r_d.mwr = 1'b0;
        case (r_q.st)
            S_ADDR: r_d.st = S_LATCH;
            S_LATCH:
            begin
                {r_d.pc_hi, r_d.pc_lo} = pc + 16'h0001;
                r_d.cnt = r_q.cnt + 2'h1;
                case (r_q.cnt)
                    2'h0: r_d.opc = prog_data;
                    2'h1: r_d.op1 = prog_data;
                    default: r_d.op2 = prog_data;
                endcase
                if (r_q.cnt == 2'h0 && dec_new.len == LEN1)
                    r_d.st = S_DECODE;
                else if (r_q.cnt != 2'h0 && r_d.cnt == dec.len)
                    r_d.st = S_DECODE;
                else
                    r_d.st = S_ADDR;
            end
            S_DECODE:
            begin
                r_d.cnt = 2'h0;
                r_d.maddr = src_addr;
                r_d.mreg = dec.regsp;
                r_d.mbank = r_q.f[FLAG_BANK];
                if (dec.src == L_MEM || dec.sec == L_MEM)
                begin
                    r_d.mrd = 1'b1;
                    r_d.st = S_MEMRD;
                end
                else
                    r_d.st = S_EXEC;
            end
            S_MEMRD: r_d.st = S_MEMDAT;
            S_MEMDAT:
            begin
                // Flag register answers at its own register-space address
                if (r_q.mreg && r_q.maddr == FLAGS_ADDR)
                    r_d.rdat = r_q.f;
                else
                    r_d.rdat = mem_rdata;
                r_d.st = S_EXEC;
            end
            S_EXEC:
            begin
                r_d.st = S_ADDR;
                r_d.done = 1'b1;
                case (dec.dst)
                    L_A: r_d.a = alu.res;
                    L_X: r_d.x = alu.res;
                    L_SP: r_d.sp = alu.res;
                    L_F: r_d.f = alu.res & FLAGS_WMASK;
                    L_MEM:
                    begin
                        r_d.maddr = dst_addr;
                        r_d.mreg = dec.regsp;
                        r_d.mbank = r_q.f[FLAG_BANK];
                        r_d.mwr = 1'b1;
                        r_d.mwdata = alu.res;
                        r_d.done = 1'b0;
                        r_d.st = S_WR;
                    end
                    default: r_d.done = 1'b1;
                endcase
                if (set_flags)
                begin
                    r_d.f[FLAG_ZERO] = (alu.res == 8'h00);
                    if (dec.op >= OP_ADD && dec.op <= OP_SBB)
                        r_d.f[FLAG_CARRY] = alu.cout;
                end
            end
            S_WR:
            begin
                r_d.done = 1'b1;
                r_d.st = S_ADDR;
            end
            default: r_d.st = S_ADDR;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            r_q <= '0;
            r_q.st <= S_ADDR;
            r_q.f <= FLAGS_RESET;
            r_q.a <= ACC_RESET;
            r_q.x <= IDX_RESET;
            r_q.sp <= SP_RESET;
            {r_q.pc_hi, r_q.pc_lo} <= PC_RESET;
        end
        else
            r_q <= r_d;
    end

    assign prog_addr = pc;
    assign mem_addr = r_q.maddr;
    assign mem_reg = r_q.mreg;
    assign mem_bank = r_q.mbank;
    assign mem_rd = r_q.mrd;
    assign mem_wr = r_q.mwr;
    assign mem_wdata = r_q.mwdata;
    assign global_interrupt_enable = r_q.f[FLAG_GIE];
    assign accumulator = r_q.a;
    assign index_register = r_q.x;
    assign stack_pointer = r_q.sp;
    assign cpu_flags = r_q.f;
    assign instr_done = r_q.done;

    property p_carry;
        @(posedge clk_sys) disable iff (rst)
        (set_flags && dec.op >= OP_ADD && dec.op <= OP_SBB)
            |=> r_q.f[FLAG_CARRY] == $past(alu.cout);
    endproperty
    a_carry: assert property (p_carry) else $error("carry mismatch");

    property p_zero;
        @(posedge clk_sys) disable iff (rst)
        set_flags |=> r_q.f[FLAG_ZERO] == ($past(alu.res) == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero mismatch");

    property p_gie;
        @(posedge clk_sys) disable iff (rst)
        $changed(global_interrupt_enable)
            |-> $past(r_q.st == S_EXEC && dec.dst == L_F);
    endproperty
    a_gie: assert property (p_gie) else $error("gie changed");

    property p_flag_read;
        @(posedge clk_sys) disable iff (rst)
        (r_q.st == S_MEMDAT && mem_reg && mem_addr == FLAGS_ADDR)
            |=> r_q.rdat == $past(r_q.f);
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("flag read");

    property p_bank;
        @(posedge clk_sys) disable iff (rst)
        (mem_rd || mem_wr) |-> mem_bank == r_q.f[FLAG_BANK];
    endproperty
    a_bank: assert property (p_bank) else $error("bank select");

    property p_acc_kept;
        @(posedge clk_sys) disable iff (rst)
        (r_q.st == S_EXEC && dec.dst == L_MEM) |=> ##1 $stable(accumulator);
    endproperty
    a_acc_kept: assert property (p_acc_kept) else $error("acc changed");

    property p_index;
        @(posedge clk_sys) disable iff (rst)
        (r_q.st == S_MEMRD && dec.idx && !dec.mem2)
            |-> mem_addr == r_q.op1 + r_q.x;
    endproperty
    a_index: assert property (p_index) else $error("index address");

    property p_pc;
        @(posedge clk_sys) disable iff (rst)
        r_q.st == S_LATCH |=> prog_addr == $past(prog_addr) + 16'h0001;
    endproperty
    a_pc: assert property (p_pc) else $error("pc advance");

    property p_move;
        @(posedge clk_sys) disable iff (rst)
        (r_q.st == S_MEMDAT && dec.mem2)
            |=> ##1 mem_wr && mem_addr == r_q.op1 && mem_wdata == r_q.rdat;
    endproperty
    a_move: assert property (p_move) else $error("mem move");
endmodule
`default_nettype wire

// ---- cpu_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpu_mem_model
(
    input wire logic clk_sys,
    input wire logic [15:0] prog_addr,
    output logic [7:0] prog_data,
    input wire logic [7:0] mem_addr,
    input wire logic mem_reg,
    input wire logic mem_bank,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] rom [0:65535];
    logic [7:0] ram [0:255];
    logic [7:0] regs [0:511];

    initial
    begin
        prog_data = 8'h00;
        mem_rdata = 8'h00;
        for (int i = 0; i < 65536; i++)
            rom[i] = 8'h40;
    end

    // Byte at the address shown one cycle earlier
    always @(posedge clk_sys)
    begin
        prog_data <= rom[prog_addr];
    end

    // Read data holds one cycle only, toggles otherwise
    always @(posedge clk_sys)
    begin
        if (mem_rd && mem_reg)
            mem_rdata <= regs[{mem_bank, mem_addr}];
        else if (mem_rd)
            mem_rdata <= ram[mem_addr];
        else
            mem_rdata <= ~mem_rdata;
        if (mem_wr && mem_reg)
            regs[{mem_bank, mem_addr}] <= mem_wdata;
        if (mem_wr && !mem_reg)
            ram[mem_addr] <= mem_wdata;
    end
endmodule
`default_nettype wire

// ---- cpu_operand_addressing_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpu_operand_addressing_tb_top;
    import cpu_addr_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [15:0] prog_addr;
    logic [7:0] prog_data;
    logic [7:0] mem_addr;
    logic mem_reg;
    logic mem_bank;
    logic mem_rd;
    logic mem_wr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic global_interrupt_enable;
    logic [7:0] accumulator;
    logic [7:0] index_register;
    logic [7:0] stack_pointer;
    logic [7:0] cpu_flags;
    logic instr_done;
    int err_total = 0;
    int tests_run = 0;
    logic [7:0] exp_a;
    logic [7:0] exp_x;
    logic [7:0] exp_sp;
    logic [7:0] exp_f;
    logic [15:0] exp_pc;
    logic [7:0] exp_ram [0:255];

    always #2 clk_sys = ~clk_sys;

    cpu_operand_addressing u_dut (
        .clk_sys(clk_sys), .rst(rst),
        .prog_addr(prog_addr), .prog_data(prog_data),
        .mem_addr(mem_addr), .mem_reg(mem_reg), .mem_bank(mem_bank),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata),
        .global_interrupt_enable(global_interrupt_enable),
        .accumulator(accumulator), .index_register(index_register),
        .stack_pointer(stack_pointer), .cpu_flags(cpu_flags),
        .instr_done(instr_done)
    );

    cpu_mem_model u_mem (
        .clk_sys(clk_sys), .prog_addr(prog_addr), .prog_data(prog_data),
        .mem_addr(mem_addr), .mem_reg(mem_reg), .mem_bank(mem_bank),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata)
    );

    task automatic tally_and_finish();
        if (err_total == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                        input string msg);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp,
                         input string msg);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic check_state();
        chk8(accumulator, exp_a, "acc");
        chk8(index_register, exp_x, "idx");
        chk8(stack_pointer, exp_sp, "sp");
        chk8(cpu_flags, exp_f, "flags");
        chk8({7'h00, global_interrupt_enable},
             {7'h00, exp_f[FLAG_GIE]}, "gie");
        chk16(prog_addr, exp_pc, "pc");
    endtask

    // Place bytes at the PC, run one instruction, check registers
    task automatic exec(input logic [7:0] b0, input logic [7:0] b1,
                        input logic [7:0] b2, input logic [1:0] len);
        int n;
        u_mem.rom[exp_pc] = b0;
        u_mem.rom[exp_pc + 16'h0001] = b1;
        u_mem.rom[exp_pc + 16'h0002] = b2;
        exp_pc = exp_pc + {14'h0000, len};
        n = 0;
        do
        begin
            @(negedge clk_sys);
            n++;
        end
        while (instr_done !== 1'b1 && n < 40);
        if (instr_done !== 1'b1)
        begin
            err_total++;
            $display("mismatch %0t no completion", $time);
            tally_and_finish();
        end
        else
            check_state();
    endtask

    // Result of second op source; updates expected carry and zero
    function automatic logic [7:0] alu_do(input logic [2:0] op,
                                          input logic [7:0] s,
                                          input logic [7:0] t);
        logic [8:0] r;
        logic c;
        c = exp_f[FLAG_CARRY];
        case (op)
            3'h1: r = {1'b0, s} + {1'b0, t};
            3'h2: r = {1'b0, s} + {1'b0, t} + {8'h00, c};
            3'h3: r = {1'b0, s} - {1'b0, t};
            3'h4: r = {1'b0, s} - {1'b0, t} - {8'h00, c};
            3'h5: r = {c, s & t};
            3'h6: r = {c, s | t};
            default: r = {c, s ^ t};
        endcase
        exp_f[FLAG_CARRY] = r[8];
        exp_f[FLAG_ZERO] = (r[7:0] == 8'h00);
        return r[7:0];
    endfunction

    initial
    begin
        logic [31:0] v;
        logic [7:0] addr;
        logic [2:0] op;
        logic [2:0] mode;
        void'($urandom(32'hE75DEC3A));
        for (int i = 0; i < 256; i++)
        begin
            v = $urandom;
            u_mem.ram[i] = v[7:0];
            exp_ram[i] = v[7:0];
        end
        for (int i = 0; i < 512; i++)
            u_mem.regs[i] = 8'hA5;
        u_mem.regs[9'h030] = 8'h3C;
        exp_a = ACC_RESET;
        exp_x = IDX_RESET;
        exp_sp = SP_RESET;
        exp_f = FLAGS_RESET;
        exp_pc = PC_RESET;
        repeat (5) @(negedge clk_sys);
        rst = 1'b0;
        check_state();
        exp_f = 8'h17;
        exec(8'h71, 8'h1F, 8'h00, LEN2);
        exp_a = 8'h5A;
        exp_f = 8'h15;
        exec(8'h50, 8'h5A, 8'h00, LEN2);
        exec(8'h60, 8'h30, 8'h00, LEN2);
        chk8(u_mem.regs[9'h130], 8'h5A, "bank1");
        exp_f = 8'h05;
        exec(8'h70, 8'hEF, 8'h00, LEN2);
        exp_a = 8'h3C;
        exec(8'h5D, 8'h30, 8'h00, LEN2);
        exec(8'h60, 8'hF7, 8'h00, LEN2);
        exp_a = 8'h05;
        exec(8'h5D, 8'hF7, 8'h00, LEN2);
        exp_ram[7] = exp_ram[8];
        exec(8'h5F, 8'h07, 8'h08, LEN3);
        chk8(u_mem.ram[7], exp_ram[7], "move");
        exp_f = 8'h00;
        exec(8'h70, 8'h00, 8'h00, LEN2);
        exp_sp = 8'h80;
        exec(8'h38, 8'h80, 8'h00, LEN2);
        exp_x = 8'h10;
        exec(8'h57, 8'h10, 8'h00, LEN2);
        exp_ram[8'h12] = 8'hC3;
        exec(8'h56, 8'h02, 8'hC3, LEN3);
        chk8(u_mem.ram[8'h12], 8'hC3, "mov idx imm");
        exec(8'h63, 8'h20, 8'h77, LEN3);
        chk8(u_mem.regs[9'h030], 8'h77, "reg idx imm");
        exp_a = 8'h77;
        exec(8'h5E, 8'h20, 8'h00, LEN2);
        exp_f = 8'h02;
        exec(8'h45, 8'h30, 8'h77, LEN3);
        chk8(u_mem.regs[9'h030], 8'h00, "reg xor");
        exp_ram[8'h20] = 8'h10;
        exec(8'h5A, 8'h20, 8'h00, LEN2);
        chk8(u_mem.ram[8'h20], 8'h10, "mov x");
        exp_x = exp_ram[8'h22];
        exec(8'h59, 8'h12, 8'h00, LEN2);
        exp_f = 8'h10;
        exec(8'h72, 8'h12, 8'h00, LEN2);
        for (int i = 0; i < 150; i++)
        begin
            v = $urandom;
            op = (v[26:24] == 3'h0) ? 3'h1 : v[26:24];
            mode = (v[29:27] == 3'h0) ? 3'h1 : v[29:27];
            exp_x = v[7:0];
            exec(8'h57, v[7:0], 8'h00, LEN2);
            addr = mode[0] ? v[15:8] + exp_x : v[15:8];
            case (mode)
                3'h1: exp_a = alu_do(op, exp_a, v[15:8]);
                3'h2, 3'h3: exp_a = alu_do(op, exp_a, exp_ram[addr]);
                3'h4, 3'h5: exp_ram[addr] = alu_do(op, exp_ram[addr], exp_a);
                default: exp_ram[addr] = alu_do(op, exp_ram[addr], v[23:16]);
            endcase
            exec({2'b00, op - 3'h1, mode}, v[15:8], v[23:16],
                 (mode > 3'h5) ? LEN3 : LEN2);
            chk8(u_mem.ram[addr], exp_ram[addr], "ram");
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
